// [src/cpl_map.svh]
// register offsets, field positions, reset values and timing counts
// holds only defines; both including files pull it in ahead of their module declaration
`ifndef CPL_MAP_SVH
`define CPL_MAP_SVH

// ****************************************
// register map
// ****************************************
`define CPL_ADDR_CAPTURE_SETUP  16'hE706
`define CPL_ADDR_REF_LOCK       16'hEC01
`define CPL_SETUP_RESET         8'h00
`define CPL_REF_LOCK_RESET      8'h00
`define CPL_BIT_CLK_SLOW        0
`define CPL_BIT_PACK8           1
`define CPL_BIT_GAP             2
`define CPL_BIT_XFER_LO         3
`define CPL_BIT_POL             5
`define CPL_BIT_EXT_REF         0
`define CPL_BIT_LOCK            1

// ****************************************
// timing
// ****************************************
`define CPL_SYS_HZ              10000000
`define CPL_CAP_HZ_FAST         8000000
`define CPL_CAP_HZ_SLOW         4000000
`define CPL_HALF_FAST  ((`CPL_SYS_HZ + 2*`CPL_CAP_HZ_FAST - 1) / (2*`CPL_CAP_HZ_FAST))
`define CPL_HALF_SLOW  ((`CPL_SYS_HZ + 2*`CPL_CAP_HZ_SLOW - 1) / (2*`CPL_CAP_HZ_SLOW))
`define CPL_GAP_CLKS            7
`define CPL_SPI_TOGGLES         3
`define CPL_WORDS_ALL           16
`define CPL_WORDS_WAVE          7
`define CPL_WORDS_POWER         9
`define CPL_POWER_FIRST         7

`endif

// [src/cpl_pkg.sv]
// types shared by the capture port and serial lock block
// assumes cpl_map.svh is on the include path
package cpl_pkg;

  typedef enum logic [1:0] {
    CPL_IDLE,
    CPL_SHIFT,
    CPL_GAP
  } cpl_state_type;

  typedef struct packed {
    logic       pol;
    logic [1:0] xfer;
    logic       gap;
    logic       pack8;
    logic       clk_slow;
  } cpl_cfg_type;

  // order matches the full sixteen word sequence, zero word left out
  typedef struct packed {
    logic [31:0] ia_wave;
    logic [31:0] va_wave;
    logic [31:0] ib_wave;
    logic [31:0] vb_wave;
    logic [31:0] ic_wave;
    logic [31:0] vc_wave;
    logic [31:0] a_apparent;
    logic [31:0] b_apparent;
    logic [31:0] c_apparent;
    logic [31:0] a_active;
    logic [31:0] b_active;
    logic [31:0] c_active;
    logic [31:0] a_reactive;
    logic [31:0] b_reactive;
    logic [31:0] c_reactive;
  } cpl_meas_type;

endpackage

// [src/cpl_capture_lock.sv]
// capture port setup, capture serializer and serial port selection lock
// assumes a host register port on clk_sys and measurement words held stable by the meter core
// Contract
// - clock select picks fast or slow capture clock; gap bit adds seven idle clocks.
// - packing clear sends 32-bit packages, set sends 8-bit packages, MSB first.
// - transfer code 00 sends sixteen words: waves, zero, apparent, active, reactive.
// - transfer code 01 sends six wave samples then one zero word.
// - transfer code 10 sends nine power words: apparent, active, reactive.
// - transfer code 11 behaves exactly like code 00.
// - polarity bit clear gives active-low frame output, set gives active-high.
// - reference select bit reports internal or external reference, default internal.
// - unlocked, three toggles of the shared pin switch the host port to SPI.
// - in I2C, setting the lock bit freezes I2C and ignores pin toggles; a third toggle in the same cycle as that write still locks SPI.
// - in SPI, any write to the second register locks SPI for good.
// - a locked port choice survives every power mode change.
// - reserved bits read zero and change nothing.
`timescale 1ns/100ps
`include "cpl_map.svh"

module cpl_capture_lock (
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  input  wire logic [15:0]           reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  cap_start,
  input  wire cpl_pkg::cpl_meas_type meas,
  output logic                       capture_serial_clock,
  output logic                       cap_data,
  output logic                       cap_busy,
  input  wire logic                  sel_frame_i,
  output logic                       sel_frame_o,
  output logic                       sel_frame_oe,
  output logic                       spi_active,
  output logic                       port_locked,
  output logic                       external_reference_select
);
  import cpl_pkg::*;

  localparam logic [1:0] HALF_FAST = 2'(`CPL_HALF_FAST);
  localparam logic [1:0] HALF_SLOW = 2'(`CPL_HALF_SLOW);
  localparam logic [4:0] GAP_HALVES = 5'(2 * `CPL_GAP_CLKS - 1);

  // ****************************************
  // register file and port lock
  // ****************************************
  cpl_cfg_type setup, next_setup;
  logic        next_ext_ref, next_spi, next_lock;
  logic [1:0]  tog_cnt, next_tog_cnt;
  logic [7:0]  next_rdata;
  logic        pin_s1, pin_s2, pin_s3;
  logic        wr_setup, wr_ref;

  assign wr_setup = reg_wr && (reg_addr == `CPL_ADDR_CAPTURE_SETUP);
  assign wr_ref   = reg_wr && (reg_addr == `CPL_ADDR_REF_LOCK);

  always_comb begin
    next_setup   = setup;
    next_ext_ref = external_reference_select;
    next_spi     = spi_active;
    next_lock    = port_locked;
    next_tog_cnt = tog_cnt;
    if (wr_setup) begin
      next_setup = cpl_cfg_type'(reg_wdata[5:0]);
    end
    if (wr_ref) begin
      next_ext_ref = reg_wdata[`CPL_BIT_EXT_REF];
      if (spi_active || reg_wdata[`CPL_BIT_LOCK]) begin
        next_lock = 1'b1;
      end
    end
    // only reset releases the lock, power mode changes never touch it
    if (!port_locked && !spi_active && (pin_s2 != pin_s3)) begin
      if (tog_cnt == 2'(`CPL_SPI_TOGGLES - 1)) begin
        next_spi = 1'b1;
      end else begin
        next_tog_cnt = tog_cnt + 2'h1;
      end
    end
    case (reg_addr)
      `CPL_ADDR_CAPTURE_SETUP: next_rdata = {2'h0, 6'(setup)};
      `CPL_ADDR_REF_LOCK:      next_rdata = {6'h00, port_locked, external_reference_select};
      default:                 next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      setup                     <= cpl_cfg_type'(6'(`CPL_SETUP_RESET));
      external_reference_select <= 1'b0;
      spi_active                <= 1'b0;
      port_locked               <= 1'b0;
      tog_cnt                   <= 2'h0;
      reg_rdata                 <= 8'h00;
      pin_s1                    <= 1'b1;
      pin_s2                    <= 1'b1;
      pin_s3                    <= 1'b1;
    end else if (clk_en) begin
      setup                     <= next_setup;
      external_reference_select <= next_ext_ref;
      spi_active                <= next_spi;
      port_locked               <= next_lock;
      tog_cnt                   <= next_tog_cnt;
      reg_rdata                 <= next_rdata;
      pin_s1                    <= sel_frame_i;
      pin_s2                    <= pin_s1;
      pin_s3                    <= pin_s2;
    end
  end

  // ****************************************
  // capture snapshot
  // ****************************************
  // snapshot at start so a transfer never mixes samples from two conversions
  logic [31:0] src  [16];
  logic [31:0] snap [16];

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_snap
      if (gi < 6) begin : g_wave
        assign src[gi] = meas[479 - 32*gi -: 32];
      end else if (gi == 6) begin : g_zero
        assign src[gi] = 32'h0000_0000;
      end else begin : g_pow
        assign src[gi] = meas[479 - 32*(gi-1) -: 32];
      end
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          snap[gi] <= 32'h0000_0000;
        end else if (clk_en && cap_start && !cap_busy) begin
          snap[gi] <= src[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // capture serializer
  // ****************************************
  cpl_state_type st, next_st;
  cpl_cfg_type   cfg_q, next_cfg_q;
  logic [1:0]    half_cnt, next_half_cnt;
  logic [4:0]    bit_cnt, next_bit_cnt;
  logic [3:0]    ptr, next_ptr;
  logic [4:0]    left, next_left;
  logic [4:0]    gap_cnt, next_gap_cnt;
  logic [31:0]   shreg, next_shreg;
  logic          next_sclk, tick, pkg_end, next_busy;

  assign tick = (half_cnt == ((cfg_q.clk_slow ? HALF_SLOW : HALF_FAST) - 2'h1));

  always_comb begin
    next_st       = st;
    next_cfg_q    = cfg_q;
    next_half_cnt = tick ? 2'h0 : half_cnt + 2'h1;
    next_bit_cnt  = bit_cnt;
    next_ptr      = ptr;
    next_left     = left;
    next_gap_cnt  = gap_cnt;
    next_shreg    = shreg;
    next_sclk     = capture_serial_clock;
    pkg_end       = 1'b0;
    case (st)
      CPL_IDLE: begin
        next_half_cnt = 2'h0;
        next_sclk     = 1'b0;
        if (cap_start) begin
          next_cfg_q   = setup;
          next_bit_cnt = 5'h00;
          next_st      = CPL_SHIFT;
          case (setup.xfer)
            2'h1: begin
              next_ptr  = 4'h0;
              next_left = 5'(`CPL_WORDS_WAVE);
            end
            2'h2: begin
              next_ptr  = 4'(`CPL_POWER_FIRST);
              next_left = 5'(`CPL_WORDS_POWER);
            end
            default: begin
              next_ptr  = 4'h0;
              next_left = 5'(`CPL_WORDS_ALL);
            end
          endcase
          next_shreg = (setup.xfer == 2'h2) ? src[`CPL_POWER_FIRST] : src[0];
        end
      end
      CPL_SHIFT: begin
        if (tick) begin
          next_sclk = !capture_serial_clock;
          if (capture_serial_clock) begin
            next_bit_cnt = bit_cnt + 5'h01;
            next_shreg   = {shreg[30:0], 1'b0};
            if (bit_cnt == 5'h1F) begin
              pkg_end   = 1'b1;
              next_left = left - 5'h01;
              next_ptr  = ptr + 4'h1;
              next_shreg = snap[ptr + 4'h1];
            end else if (cfg_q.pack8 && (bit_cnt[2:0] == 3'h7)) begin
              pkg_end = 1'b1;
            end
            if (bit_cnt == 5'h1F && left == 5'h01) begin
              next_st = CPL_IDLE;
            end else if (pkg_end && cfg_q.gap) begin
              next_st      = CPL_GAP;
              next_gap_cnt = 5'h00;
            end
          end
        end
      end
      CPL_GAP: begin
        next_sclk = 1'b0;
        if (tick) begin
          next_gap_cnt = gap_cnt + 5'h01;
          if (gap_cnt == GAP_HALVES) begin
            next_st = CPL_SHIFT;
          end
        end
      end
      default: begin
        next_st = CPL_IDLE;
      end
    endcase
    next_busy = (next_st != CPL_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st                   <= CPL_IDLE;
      cfg_q                <= cpl_cfg_type'(6'(`CPL_SETUP_RESET));
      half_cnt             <= 2'h0;
      bit_cnt              <= 5'h00;
      ptr                  <= 4'h0;
      left                 <= 5'h00;
      gap_cnt              <= 5'h00;
      shreg                <= 32'h0000_0000;
      capture_serial_clock <= 1'b0;
      cap_data             <= 1'b0;
      cap_busy             <= 1'b0;
      sel_frame_o          <= 1'b1;
      sel_frame_oe         <= 1'b0;
    end else if (clk_en) begin
      st                   <= next_st;
      cfg_q                <= next_cfg_q;
      half_cnt             <= next_half_cnt;
      bit_cnt              <= next_bit_cnt;
      ptr                  <= next_ptr;
      left                 <= next_left;
      gap_cnt              <= next_gap_cnt;
      shreg                <= next_shreg;
      capture_serial_clock <= next_sclk;
      cap_data             <= next_busy ? next_shreg[31] : 1'b0;
      cap_busy             <= next_busy;
      // polarity is taken live while idle, frozen in cfg_q during a transfer
      sel_frame_o          <= next_busy ? next_cfg_q.pol : !setup.pol;
      // the shared pin only becomes the frame output once I2C is locked in
      sel_frame_oe         <= next_lock && !next_spi;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_frame_pol;
    @(posedge clk_sys) disable iff (sys_rst)
    cap_busy |-> (sel_frame_o == cfg_q.pol);
  endproperty
  a_frame_pol: assert property (p_frame_pol) else $error("frame level wrong");

  property p_gap_only_if_enabled;
    @(posedge clk_sys) disable iff (sys_rst)
    (st == CPL_GAP) |-> (cfg_q.gap && !capture_serial_clock && cap_busy);
  endproperty
  a_gap_only_if_enabled: assert property (p_gap_only_if_enabled) else $error("bad gap");

  property p_gap_len;
    @(posedge clk_sys) disable iff (sys_rst)
    (st == CPL_GAP) |-> (gap_cnt <= GAP_HALVES);
  endproperty
  a_gap_len: assert property (p_gap_len) else $error("gap too long");

  property p_word_count;
    @(posedge clk_sys) disable iff (sys_rst || !clk_en)
    (st == CPL_IDLE && cap_start) |=> (left == ((setup.xfer == 2'h1) ? 5'd7 :
                                                (setup.xfer == 2'h2) ? 5'd9 : 5'd16));
  endproperty
  a_word_count: assert property (p_word_count) else $error("word count wrong");

  property p_wave_range;
    @(posedge clk_sys) disable iff (sys_rst)
    (cap_busy && cfg_q.xfer == 2'h1) |-> (ptr < 4'h7);
  endproperty
  a_wave_range: assert property (p_wave_range) else $error("wave set overran");

  property p_power_range;
    @(posedge clk_sys) disable iff (sys_rst)
    (cap_busy && cfg_q.xfer == 2'h2) |-> (ptr >= 4'h7);
  endproperty
  a_power_range: assert property (p_power_range) else $error("power set wrong");

  property p_spi_needs_unlock;
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(spi_active) |-> !$past(port_locked);
  endproperty
  a_spi_needs_unlock: assert property (p_spi_needs_unlock) else $error("spi after lock");

  property p_i2c_held;
    @(posedge clk_sys) disable iff (sys_rst)
    (port_locked && !spi_active) |=> (!spi_active && port_locked);
  endproperty
  a_i2c_held: assert property (p_i2c_held) else $error("i2c lock lost");

  property p_spi_lock;
    @(posedge clk_sys) disable iff (sys_rst || !clk_en)
    (spi_active && wr_ref) |=> port_locked ##1 port_locked;
  endproperty
  a_spi_lock: assert property (p_spi_lock) else $error("spi not locked");

  c_full_xfer: cover property (@(posedge clk_sys) $fell(cap_busy) && cfg_q.xfer == 2'h0);
  c_gap_seen:  cover property (@(posedge clk_sys) $rose(st == CPL_GAP));
  c_spi_on:    cover property (@(posedge clk_sys) $rose(spi_active));
  c_i2c_lock:  cover property (@(posedge clk_sys) $rose(sel_frame_oe));

endmodule

// [bench/cpl_cap_rx.sv]
// capture receiver model: gathers 32-bit words from the capture link
// assumes clock, data and frame come registered from the block on clk_sys
`timescale 1ns/100ps

module cpl_cap_rx (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        active_pol,
  input  wire logic        sclk,
  input  wire logic        sdata,
  input  wire logic        frame,
  output logic             rx_done,
  output logic [31:0]      rx_word
);
  logic        sclk_q;
  logic [4:0]  nbits;
  logic [31:0] shift;

  // an inactive frame clears the count, so every transfer starts word aligned
  always_ff @(posedge clk_sys) begin
    sclk_q  <= sclk;
    rx_done <= 1'b0;
    if (sys_rst || frame != active_pol) begin
      nbits <= 5'h00;
    end else if (sclk && !sclk_q) begin
      shift <= {shift[30:0], sdata};
      nbits <= nbits + 5'h01;
      if (nbits == 5'h1F) begin
        rx_done <= 1'b1;
        rx_word <= {shift[30:0], sdata};
      end
    end
  end
endmodule

// [bench/tb_cpl_capture_lock.sv]
// self-checking bench for the capture setup and serial port lock block
// assumes the capture receiver model and the design package are compiled first
`timescale 1ns/100ps
`include "cpl_map.svh"

module tb_cpl_capture_lock;
  import cpl_pkg::*;

  logic         clk_sys = 1'b0;
  logic         sys_rst = 1'b1;
  logic         clk_en = 1'b1;
  logic [15:0]  reg_addr = 16'h0000;
  logic [7:0]   reg_wdata = 8'h00;
  logic         reg_wr = 1'b0;
  logic [7:0]   reg_rdata;
  logic         cap_start = 1'b0;
  cpl_meas_type meas;
  logic         sclk;
  logic         cap_data;
  logic         cap_busy;
  logic         host_pin = 1'b1;
  logic         sel_wire;
  logic         sel_frame_o;
  logic         sel_frame_oe;
  logic         spi_active;
  logic         port_locked;
  logic         ext_ref;
  logic         pol = 1'b0;
  logic         rx_done;
  logic [31:0]  rx_word;
  int           n_errors = 0;
  int           tests_run = 0;

  // the shared pin belongs to the block once it drives it, else to the host
  assign sel_wire = sel_frame_oe ? sel_frame_o : host_pin;

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  cpl_capture_lock dut (
    .clk_sys                   (clk_sys),
    .sys_rst                   (sys_rst),
    .clk_en                    (clk_en),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_wr                    (reg_wr),
    .reg_rdata                 (reg_rdata),
    .cap_start                 (cap_start),
    .meas                      (meas),
    .capture_serial_clock      (sclk),
    .cap_data                  (cap_data),
    .cap_busy                  (cap_busy),
    .sel_frame_i               (sel_wire),
    .sel_frame_o               (sel_frame_o),
    .sel_frame_oe              (sel_frame_oe),
    .spi_active                (spi_active),
    .port_locked               (port_locked),
    .external_reference_select (ext_ref)
  );

  cpl_cap_rx rx (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .active_pol (pol),
    .sclk       (sclk),
    .sdata      (cap_data),
    .frame      (sel_frame_o),
    .rx_done    (rx_done),
    .rx_word    (rx_word)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] mw(input int k);
    return 32'h81C3_A5F0 ^ (32'h1111_1111 * k[31:0]);
  endfunction

  function automatic logic [31:0] exp_word(input logic [1:0] xf, input int i);
    if (xf == 2'b10) return mw(i + 6);
    if (i < 6) return mw(i);
    if (i == 6) return 32'h0000_0000;
    return mw(i - 1);
  endfunction

  task automatic wrap_up();
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] e, input string msg);
    tests_run++;
    if (got !== e) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, e);
    end
  endtask

  task automatic check_bit(input logic got, input logic e, input string msg);
    check({31'h0, got}, {31'h0, e}, msg);
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input string msg);
    @(posedge clk_sys);
    reg_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1;
    check({24'h0, reg_rdata}, {24'h0, e}, msg);
  endtask

  // host side of the shared pin; edges four clocks apart so the synchroniser sees each one
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_sys);
      host_pin <= ~host_pin;
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // one transfer; a second start mid-run must be ignored, stall freezes ten cycles
  task automatic run_cap(input logic [7:0] cfg, input bit stall);
    logic [1:0] xf;
    int         half, nw, npk, busy_exp, busy_n, idle_n, k, i;
    xf = cfg[4:3];
    half = cfg[0] ? 2 : 1;
    nw = (xf == 2'b01) ? 7 : (xf == 2'b10) ? 9 : 16;
    npk = cfg[1] ? nw * 4 : nw;
    busy_exp = nw * 64 * half + (cfg[2] ? (npk - 1) * 14 * half : 0) + (stall ? 10 : 0);
    busy_n = 0;
    idle_n = 0;
    k = 0;
    pol = cfg[5];
    wr_reg(`CPL_ADDR_CAPTURE_SETUP, cfg);
    rd_chk(`CPL_ADDR_CAPTURE_SETUP, {2'b00, cfg[5:0]}, "setup readback");
    @(posedge clk_sys);
    cap_start <= 1'b1;
    for (i = 0; i < 5000 && idle_n < 3; i++) begin
      @(posedge clk_sys);
      cap_start <= (i == 8);
      clk_en <= !(stall && i >= 20 && i < 30);
      #1;
      if (cap_busy === 1'b1) begin
        busy_n++;
        check_bit(sel_frame_o, pol, "frame level in transfer");
      end else if (busy_n > 0) begin
        idle_n++;
      end
      if (rx_done === 1'b1) begin
        check(rx_word, exp_word(xf, k), "captured word");
        k++;
      end
    end
    if (i == 5000) begin
      check_bit(1'b0, 1'b1, "capture timeout");
      wrap_up();
    end
    check(k[31:0], nw[31:0], "word count");
    check(busy_n[31:0], busy_exp[31:0], "transfer length");
    check_bit(sel_frame_o, !pol, "idle frame level");
  endtask

  task automatic spi_lock();
    toggle(2);
    repeat (8) @(posedge clk_sys);
    #1;
    check_bit(spi_active, 1'b0, "two toggles");
    toggle(1);
    repeat (8) @(posedge clk_sys);
    #1;
    check_bit(spi_active, 1'b1, "three toggles");
    wr_reg(`CPL_ADDR_REF_LOCK, 8'h00);
    rd_chk(`CPL_ADDR_REF_LOCK, 8'h02, "spi lock readback");
    check_bit(port_locked, 1'b1, "spi lock output");
    check_bit(sel_frame_oe, 1'b0, "pin stays input in spi");
  endtask

  // once locked in i2c, frame edges on the shared pin must not count as toggles
  task automatic i2c_lock();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    wr_reg(`CPL_ADDR_REF_LOCK, 8'hFF);
    rd_chk(`CPL_ADDR_REF_LOCK, 8'h03, "i2c lock readback");
    check_bit(ext_ref, 1'b1, "external reference");
    check_bit(sel_frame_oe, 1'b1, "pin driven in i2c");
    run_cap(8'h00, 1'b0);
    run_cap(8'h20, 1'b0);
    toggle(4);
    repeat (8) @(posedge clk_sys);
    #1;
    check_bit(spi_active, 1'b0, "no switch after lock");
  endtask

  initial begin
    for (int k = 0; k < 15; k++) meas[479 - 32 * k -: 32] = mw(k);
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd_chk(`CPL_ADDR_CAPTURE_SETUP, 8'h00, "setup reset");
    rd_chk(`CPL_ADDR_REF_LOCK, 8'h00, "ref lock reset");
    rd_chk(16'hE707, 8'h00, "unmapped read");
    run_cap(8'h00, 1'b0);
    run_cap(8'h0E, 1'b1);
    run_cap(8'h31, 1'b0);
    run_cap(8'hDB, 1'b0);
    run_cap(8'h2C, 1'b0);
    spi_lock();
    i2c_lock();
    wrap_up();
  end
endmodule
